// ===== dv/host_ctrl_model.sv
`timescale 1ns/1ns
module host_ctrl_model (
  // Link pins toward the device
  output logic host_clk,
  output logic sel_n,
  output logic [7:0] host_dq,
  // What the device drives back
  input flash_pkg::bus_drive_t bus_in
);
  int cyc; // Host cycle of the frame, -1 before the first rise
  logic [7:0] hi_byte; // High byte held until the falling strobe
  logic [15:0] words[$]; // Captured words, in arrival order
  int cyc_q[$]; // Host cycle in which each word began

  initial begin
    host_clk = 1'b0;
    sel_n = 1'b1;
    host_dq = 8'h00;
    cyc = -1;
  end

  // strobe as capture
  // Sample after a short shift so the aligned data has settled
  // Undriven lines read as unknown, so a missing enable shows up
  always @(posedge bus_in.strobe) begin
    #10;
    hi_byte = bus_in.dq_oe ? bus_in.dq : 8'hxx;
    if (!sel_n && bus_in.strobe_oe) cyc_q.push_back(cyc);
  end

  always @(negedge bus_in.strobe) begin
    #10;
    if (!sel_n && bus_in.strobe_oe)
      words.push_back({hi_byte, bus_in.dq_oe ? bus_in.dq : 8'hxx});
  end

  // command in cycles 0-2
  // Bytes sit mid-way between edges; the clock stands low outside frames
  task automatic read_frame(input logic [47:0] ca, input int n_cyc);
    words.delete();
    cyc_q.delete();
    cyc = -1;
    sel_n = 1'b0;
    #200;
    for (int c = 0; c < n_cyc; c++) begin
      // Released lines change every cycle, so no stale value survives
      if (c < 3) host_dq = ca[47-16*c -: 8];
      else host_dq = ~host_dq;
      #100;
      host_clk = 1'b1;
      cyc = c;
      #100;
      if (c < 3) host_dq = ca[39-16*c -: 8];
      #100;
      host_clk = 1'b0;
      #100;
    end
    #200;
    sel_n = 1'b1;
    host_dq = ~host_dq;
  endtask
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic clk, rst_n;
  logic [1:0] cfg_wrap_size; // Wrap-size field, static per frame
  logic page_stall, ecc_stall;
  logic core_valid, core_ready, starve; // Starve holds the array off
  logic [15:0] core_data;
  logic [31:0] fetch_addr;
  logic host_clk, sel_n;
  logic [7:0] host_dq, dq_in;
  flash_pkg::bus_drive_t bus_out;
  int fail_count, n_checks;

  // Shared lines: the device drive wins while enabled
  assign dq_in = bus_out.dq_oe ? bus_out.dq : host_dq;

  ddr_read_burst_strobe u_dut (
    .clk(clk), .rst_n(rst_n), .host_clk_pin(host_clk), .sel_n_pin(sel_n),
    .dq_in(dq_in), .bus_out(bus_out), .cfg_wrap_size(cfg_wrap_size),
    .page_stall(page_stall), .ecc_stall(ecc_stall),
    .fetch_addr(fetch_addr), .core_valid(core_valid),
    .core_data(core_data), .core_ready(core_ready)
  );

  host_ctrl_model u_host (
    .host_clk(host_clk), .sel_n(sel_n), .host_dq(host_dq), .bus_in(bus_out)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Word content tied to its address so order errors show
  function automatic logic [15:0] word_of(input logic [31:0] a);
    return {a[7:0] ^ 8'h5a, a[15:8] ^ a[7:0]};
  endfunction

  // Array stream: always ready with a word unless starved
  always @(negedge clk) begin
    core_data <= word_of(fetch_addr);
    core_valid <= !starve;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Bounded wait for a host cycle; running out ends the run
  task automatic wait_cyc(input int n);
    int k;
    k = 0;
    while (u_host.cyc < n && k < 4000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 4000) begin
      fail_count++;
      $display("[ERR] host_cycle expected %0d seen %0d", n, u_host.cyc);
      tally_and_finish();
    end
  endtask

  // Linear read with a wrap field set, stalls, starvation and abort
  task automatic run_linear();
    logic [31:0] start;
    start = 32'h0012_3403;
    @(negedge clk);
    cfg_wrap_size = 2'h2;
    fork
      u_host.read_frame({2'b00, 1'b1, 13'h0000, start}, 56);
      begin
        wait_cyc(15);
        // Eight words buffered during latency, then the array is held
        check("fill_addr", fetch_addr, start + 32'h8);
        check("fill_ready", {31'h0, core_ready}, 32'h0);
        wait_cyc(22);
        page_stall = 1'b1;
        wait_cyc(24);
        page_stall = 1'b0;
        wait_cyc(27);
        ecc_stall = 1'b1;
        wait_cyc(28);
        ecc_stall = 1'b0;
        starve = 1'b1;
        wait_cyc(40);
        starve = 1'b0;
      end
    join
    repeat (6) @(negedge clk);
    check("abort_bus", 32'(bus_out), 32'h0);
    check("abort_ready", {31'h0, core_ready}, 32'h0);
    check("lin_first_cyc", u_host.cyc_q[0], 32'd18);
    check("lin_run_cyc", u_host.cyc_q[3], 32'd21);
    check("page_stall_cyc", u_host.cyc_q[4], 32'd24);
    check("ecc_stall_cyc", u_host.cyc_q[7], 32'd28);
    check("lin_count", {31'h0, u_host.words.size() > 20}, 32'h1);
    foreach (u_host.words[k]) begin
      check("lin_word", u_host.words[k], word_of(start + k));
    end
  endtask

  // One wrapped frame: order, length, idle gap and first-data cycle
  task automatic run_wrap(input logic [1:0] wsel, input logic [31:0] start,
                          input int len);
    logic [31:0] mask;
    int gap;
    int first;
    mask = len - 1;
    gap = (len == 32) ? int'(start[2:0]) : 0;
    first = 16 - gap;
    @(negedge clk);
    cfg_wrap_size = wsel;
    u_host.read_frame({16'h0000, start}, 18 + len + gap + 4);
    repeat (6) @(negedge clk);
    // Exactly one group, then the strobe stays still
    check("wrap_count", u_host.words.size(), len);
    check("wrap_strobes", u_host.cyc_q.size(), len);
    for (int k = 0; k < len; k++) begin
      check("wrap_word", u_host.words[k],
            word_of((start & ~mask) | ((start + k) & mask)));
      check("wrap_cyc", u_host.cyc_q[k],
            18 + k + ((k >= first) ? gap : 0));
    end
  endtask

  initial begin
    rst_n = 1'b0;
    cfg_wrap_size = 2'h0;
    page_stall = 1'b0;
    ecc_stall = 1'b0;
    starve = 1'b0;
    fail_count = 0;
    n_checks = 0;
    repeat (8) @(negedge clk);
    check("reset_bus", 32'(bus_out), 32'h0);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    run_linear();
    run_wrap(2'h2, 32'h0012_340c, 8);
    run_wrap(2'h2, 32'h0012_3402, 8);
    run_wrap(2'h3, 32'h0012_341e, 16);
    run_wrap(2'h3, 32'h0012_340a, 16);
    run_wrap(2'h1, 32'h0012_342e, 32);
    run_wrap(2'h1, 32'h0012_3403, 32);
    run_wrap(2'h1, 32'h0012_3420, 32);
    tally_and_finish();
  end
endmodule

// ===== rtl/ddr_read_burst_strobe.sv
`timescale 1ns/1ns
`include "flash_params.svh"
module ddr_read_burst_strobe (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Host pins, asynchronous to clk
  input wire logic host_clk_pin,
  input wire logic sel_n_pin,
  input wire logic [7:0] dq_in,
  // Drive toward the host pins
  output flash_pkg::bus_drive_t bus_out,
  // Static configuration and array stalls
  input wire logic [1:0] cfg_wrap_size,
  input wire logic page_stall,
  input wire logic ecc_stall,
  // Array read stream
  output logic [`ADDR_W-1:0] fetch_addr,
  input wire logic core_valid,
  input wire logic [`WORD_W-1:0] core_data,
  output logic core_ready
);

  // Synchroniser stages; stage one is read only by stage two
  logic ck_s1, ck_s2, ck_s3;
  logic sel_s1, sel_s2;
  logic [7:0] dq_s1, dq_s2;
  // Frame sequencing
  flash_pkg::seq_state_t state_reg, state_next;
  logic [5:0] cyc_reg;
  logic [2:0] byte_cnt_reg;
  logic [`CA_W-1:0] ca_reg;
  // Burst set-up latched at the end of the command phase
  logic linear_reg;
  logic [4:0] mask_reg;
  logic [2:0] start_off_reg;
  // Address side
  logic [`ADDR_W-1:0] addr_reg;
  logic issue_on_reg;
  logic [5:0] issue_cnt_reg;
  // Drain side
  logic [5:0] sent_cnt_reg;
  logic [2:0] idle_cnt_reg;
  logic [7:0] low_byte_reg;
  logic low_pend_reg;
  flash_pkg::bus_drive_t bus_reg;

  // Decoded wires
  logic ck_rise, ck_fall, ck_edge, selected; // Host edges, select
  logic [`CA_W-1:0] ca_full; // Command word with the newest byte
  logic ca_done, linear_w; // Command end and burst kind
  logic [4:0] mask_w; // Group mask from the wrap field
  logic [`ADDR_W-1:0] mask32, addr_inc, addr_step; // Address walk
  logic [5:0] grp_len, gap_at; // Group length and gap position
  logic issue_go, issue_last, wrap64, idle_gap, hold, data_slot, pop;
  logic fifo_in_ready, fifo_out_valid; // Buffer handshakes
  logic [`WORD_W-1:0] fifo_out_data; // Word at the buffer head

  // Bring host pins into the clk domain, two flops each, plus a third clk flop on the host clock for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      ck_s1 <= host_clk_pin;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      sel_s1 <= ~sel_n_pin;
      sel_s2 <= sel_s1;
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // Host clock edges; dq has the same delay so it lines up
  assign ck_rise = ck_s2 & ~ck_s3;
  assign ck_fall = ~ck_s2 & ck_s3;
  assign ck_edge = ck_rise | ck_fall;
  assign selected = sel_s2;

  // Six command-address bytes, first byte is the top
  assign ca_full = {ca_reg[`CA_W-9:0], dq_s2};
  assign ca_done = (state_reg == flash_pkg::ST_CMD) & ck_edge &
                   (byte_cnt_reg == `CA_LAST_BYTE);

  // (RULE_08) hybrid order is served as linear
  // (RULE_11) kind bit decode
  assign linear_w = ca_full[`BURST_KIND_BIT] |
                    (cfg_wrap_size == `WRAP_SEL_NONE);

  // (RULE_12) wrap size select
  assign mask_w = (cfg_wrap_size == `WRAP_SEL_16B) ? `MASK_16B :
                  (cfg_wrap_size == `WRAP_SEL_32B) ? `MASK_32B :
                  (cfg_wrap_size == `WRAP_SEL_64B) ? `MASK_64B : 5'h00;

  // (RULE_09) linear next address
  assign addr_inc = addr_reg + 32'h0000_0001;
  assign mask32 = {27'h0000000, mask_reg};
  // (RULE_13) stay inside aligned group
  assign addr_step = linear_reg ? addr_inc :
                     ((addr_reg & ~mask32) | (addr_inc & mask32));
  // (RULE_15) 64-byte group is 32 words
  assign grp_len = {1'b0, mask_reg} + 6'h01;

  // Address side handshake; the full buffer stalls the array
  assign core_ready = issue_on_reg & fifo_in_ready & selected;
  assign issue_go = core_valid & core_ready;
  // (RULE_14) wrapped bursts stop after one group
  assign issue_last = ~linear_reg & (issue_cnt_reg == grp_len - 6'h01);
  assign fetch_addr = addr_reg;

  // (RULE_17) idle gap position and length
  assign wrap64 = ~linear_reg & (mask_reg == `MASK_64B);
  assign gap_at = `HALF_GROUP - {3'h0, start_off_reg};
  assign idle_gap = wrap64 & (start_off_reg != 3'h0) &
                    (sent_cnt_reg == gap_at) &
                    (idle_cnt_reg < start_off_reg);

  // (RULE_07) stalls freeze the strobe
  assign hold = page_stall | ecc_stall | idle_gap;
  // (RULE_16) data slots from cycle 18
  assign data_slot = ck_rise & selected & (cyc_reg >= `FIRST_DATA_CYCLE) &
                     ((state_reg == flash_pkg::ST_LAT) |
                      (state_reg == flash_pkg::ST_DATA));
  // (RULE_05) send only when a word is ready
  assign pop = data_slot & ~hold & fifo_out_valid;

  // Next state of the frame
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      flash_pkg::ST_IDLE: begin
        if (selected) begin
          state_next = flash_pkg::ST_CMD;
        end
      end
      flash_pkg::ST_CMD: begin
        if (ca_done) begin
          state_next = flash_pkg::ST_LAT;
        end
      end
      flash_pkg::ST_LAT: begin
        if (data_slot) begin
          state_next = flash_pkg::ST_DATA;
        end
      end
      flash_pkg::ST_DATA: begin
        // (RULE_06) keep sending until deselect
        state_next = flash_pkg::ST_DATA;
      end
      default: begin
        state_next = flash_pkg::ST_IDLE;
      end
    endcase
    // (RULE_18) deselect ends the frame
    if (!selected) begin
      state_next = flash_pkg::ST_IDLE;
    end
  end

  // State and host cycle count, cycle 0 is the first rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= flash_pkg::ST_IDLE;
      cyc_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      if (!selected) begin
        cyc_reg <= 6'h00;
      end else if (ck_rise && cyc_reg != `CYC_SAT) begin
        cyc_reg <= cyc_reg + 6'h01;
      end
    end
  end

  // Collect command bytes on both host clock edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_cnt_reg <= 3'h0;
      ca_reg <= 48'h0000_0000_0000;
    end else if (!selected) begin
      byte_cnt_reg <= 3'h0;
    end else if (state_next == flash_pkg::ST_CMD && ck_edge) begin
      byte_cnt_reg <= byte_cnt_reg + 3'h1;
      ca_reg <= ca_full;
    end
  end

  // Latch burst kind, group and start at the last command byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linear_reg <= 1'b1;
      mask_reg <= 5'h00;
      start_off_reg <= 3'h0;
    end else if (ca_done) begin
      linear_reg <= linear_w;
      mask_reg <= mask_w;
      start_off_reg <= ca_full[2:0];
    end
  end

  // (RULE_10) fetch address walk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 32'h0000_0000;
      issue_on_reg <= 1'b0;
      issue_cnt_reg <= 6'h00;
    end else if (!selected) begin
      issue_on_reg <= 1'b0;
      issue_cnt_reg <= 6'h00;
    end else if (ca_done) begin
      addr_reg <= ca_full[`ADDR_W-1:0];
      issue_on_reg <= 1'b1;
      issue_cnt_reg <= 6'h00;
    end else if (issue_go) begin
      addr_reg <= addr_step;
      issue_cnt_reg <= issue_cnt_reg + 6'h01;
      if (issue_last) begin
        issue_on_reg <= 1'b0;
      end
    end
  end

  // Words sent and idle cycles already spent in the gap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sent_cnt_reg <= 6'h00;
      idle_cnt_reg <= 3'h0;
    end else if (!selected) begin
      sent_cnt_reg <= 6'h00;
      idle_cnt_reg <= 3'h0;
    end else begin
      if (pop) begin
        sent_cnt_reg <= sent_cnt_reg + 6'h01;
      end
      if (data_slot && idle_gap) begin
        idle_cnt_reg <= idle_cnt_reg + 3'h1;
      end
    end
  end

  // Pin drive: high byte with strobe high on the rise,
  // low byte with strobe low on the fall of the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_reg <= '0;
      low_byte_reg <= 8'h00;
      low_pend_reg <= 1'b0;
    end else if (!selected) begin
      // (RULE_18) release the pins
      bus_reg <= '0;
      low_pend_reg <= 1'b0;
    end else if (pop) begin
      // (RULE_02) data and strobe together
      bus_reg.dq <= fifo_out_data[15:8];
      bus_reg.strobe <= 1'b1;
      bus_reg.dq_oe <= 1'b1;
      bus_reg.strobe_oe <= 1'b1;
      low_byte_reg <= fifo_out_data[7:0];
      low_pend_reg <= 1'b1;
    end else if (ck_fall && low_pend_reg) begin
      // (RULE_03) second edge for low byte
      bus_reg.dq <= low_byte_reg;
      bus_reg.strobe <= 1'b0;
      low_pend_reg <= 1'b0;
    end else if (data_slot) begin
      // (RULE_01) drive strobe low while stalled
      bus_reg.dq_oe <= 1'b1;
      bus_reg.strobe_oe <= 1'b1;
    end
  end

  assign bus_out = bus_reg;

  // Buffer between the array stream and the pins
  word_fifo #(.WIDTH(`WORD_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(~selected),
    .in_valid(core_valid & issue_on_reg & selected),
    .in_ready(fifo_in_ready),
    .in_data(core_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  // Strobe rises only on a sent word
  property p_rise_on_pop;
    @(posedge clk) disable iff (!rst_n)
    $rose(bus_reg.strobe) |-> $past(pop);
  endproperty
  a_rise_on_pop: assert property (p_rise_on_pop) // RULE_03
    else $error("strobe rose without a word");

  // High byte appears with the strobe rise
  property p_edge_aligned;
    @(posedge clk) disable iff (!rst_n)
    pop |=> bus_reg.strobe && bus_reg.dq == $past(fifo_out_data[15:8]);
  endproperty
  a_edge_aligned: assert property (p_edge_aligned) // RULE_02
    else $error("data and strobe not aligned");

  // While selected, the strobe falls only on a host clock fall
  property p_fall_on_fall;
    @(posedge clk) disable iff (!rst_n)
    ($fell(bus_reg.strobe) && selected) |-> $past(ck_fall);
  endproperty
  a_fall_on_fall: assert property (p_fall_on_fall) // RULE_02
    else $error("strobe fell off a host fall");

  // No data before host cycle 18
  property p_first_cycle;
    @(posedge clk) disable iff (!rst_n)
    $rose(bus_reg.strobe) |-> cyc_reg > `FIRST_DATA_CYCLE;
  endproperty
  a_first_cycle: assert property (p_first_cycle) // RULE_16
    else $error("data before first data cycle");

  // Stalls keep the strobe still
  property p_stall_hold;
    @(posedge clk) disable iff (!rst_n)
    (data_slot && (page_stall || ecc_stall)) |=> !$rose(bus_reg.strobe);
  endproperty
  a_stall_hold: assert property (p_stall_hold) // RULE_07
    else $error("strobe moved during a stall");

  // Wrapped addresses never leave their group
  property p_wrap_group;
    @(posedge clk) disable iff (!rst_n)
    (issue_go && !linear_reg) |=>
      (addr_reg & ~mask32) == $past(addr_reg & ~mask32);
  endproperty
  a_wrap_group: assert property (p_wrap_group) // RULE_10
    else $error("wrapped address left its group");

  // Linear addresses step by one word
  property p_linear_step;
    @(posedge clk) disable iff (!rst_n)
    (issue_go && linear_reg) |=> addr_reg == $past(addr_inc);
  endproperty
  a_linear_step: assert property (p_linear_step) // RULE_09
    else $error("linear address did not increment");

  // Deselect releases both pins on the next clk edge
  property p_release;
    @(posedge clk) disable iff (!rst_n)
    !selected |=> !bus_reg.strobe_oe && !bus_reg.dq_oe;
  endproperty
  a_release: assert property (p_release) // RULE_18
    else $error("pins driven while deselected");

  // Gap cycles carry no strobe edge
  property p_gap_idle;
    @(posedge clk) disable iff (!rst_n)
    (data_slot && idle_gap) |=> !$rose(bus_reg.strobe);
  endproperty
  a_gap_idle: assert property (p_gap_idle) // RULE_17
    else $error("strobe toggled in the half gap");

endmodule

// ===== rtl/flash_params.svh
// Notes on behaviour
// (RULE_01) Flash drives strobe only with read data
// (RULE_02) Strobe edges align with data edges
// (RULE_03) One strobe transition per data byte
// (RULE_04) Host phase-shifts strobe to capture data
// (RULE_05) Strobe starts toggling at first valid data
// (RULE_06) Strobe toggles while selected and clocked
// (RULE_07) Page latency or ECC stall holds strobe
// (RULE_08) Linear, wrapped and hybrid burst orders; the code has only the linear and wrapped orders
// (RULE_09) Linear burst increments from start address
// (RULE_10) Wrapped burst returns to group start
// (RULE_11) Kind bit set forces linear burst
// (RULE_12) Wrap field 10/11/01 gives 16/32/64 bytes
// (RULE_13) Wrap counts words in aligned group
// (RULE_14) 32-byte wrap covers 16 words
// (RULE_15) 64-byte wrap covers 32 words
// (RULE_16) Command cycles 0-2, first data cycle 18
// (RULE_17) 64-byte wrap half crossing inserts idle cycles
// (RULE_18) Chip select high stops driving, drops burst
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

// Data and address widths
`define WORD_W 16
`define BYTE_W 8
`define ADDR_W 32
`define CA_W 48

// Command-address phase: six bytes over cycles 0 to 2
`define CA_LAST_BYTE 3'h5
`define BURST_KIND_BIT 45

// Latency code 16: first data word in host cycle 18
`define FIRST_DATA_CYCLE 6'h12
`define CYC_SAT 6'h3f

// Wrap-size field encodings
`define WRAP_SEL_16B 2'h2
`define WRAP_SEL_32B 2'h3
`define WRAP_SEL_64B 2'h1
`define WRAP_SEL_NONE 2'h0

// Word masks of the wrap groups
`define MASK_16B 5'h07
`define MASK_32B 5'h0f
`define MASK_64B 5'h1f

// Words in one half of a 64-byte group
`define HALF_GROUP 6'h10

// Output buffer depth
`define FIFO_DEPTH 8

`endif

// ===== rtl/flash_pkg.sv
package flash_pkg;

  // Sequencer states of one read frame
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CMD,
    ST_LAT,
    ST_DATA
  } seq_state_t;

  // Everything the device drives onto the octal bus
  typedef struct packed {
    logic [7:0] dq;
    logic dq_oe;
    logic strobe;
    logic strobe_oe;
  } bus_drive_t;

endpackage

// ===== rtl/word_fifo.sv
`timescale 1ns/1ns
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_reg];

  // Storage write, no reset needed for data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap at the depth; flush empties in one edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule
